/* ppid_core.sv */
// Pre-derivative velocity PID controller stepped by the scan engine.
`timescale 1ns/1ps
// How it works
// - Enable low initializes; high runs, flags executions.
// - Process input passes first-order coefficient filter.
// - Velocity increment from error, integral, derivative.
// - Incomplete derivative acts on PV, eta 0.1.
// - Direct subtracts increment, reverse adds it.
// - Integral stopped when clamped in same direction.
// - Nonzero gap width applies error dead-band.
// - PV, setpoints 0..10000; gain 0..32767.
// - MV-type words span -2500..12500.
// - Setpoint, manual and MV rate limits.
// - Calculation runs once every n scans.
// - Interval count below one counts as one.
// - Engine calls at constant 10..200 ms scans.
// - Init copies mode, initial setpoint, manual MV.
// - Init clears working state, keeps MV.
// - Auto: rate-limited setpoint, clamps, MV copy.
// - Manual: MV follows manual input, rate only.
// - Cascade: cascade setpoint, clamps, copies back.
// - Tracking bit drives MV from tracking input in auto and cascade.
// - Tracking release resumes from present MV.
module ppid_core
    import ppid_pkg::*;
#(
    parameter int SCAN_MS = 10      // Constant scan period in milliseconds.
)
(
    input  wire logic               clk_sys_in,             // 10 MHz system clock.
    input  wire logic               sys_rst_in,             // Synchronous reset, active high.
    input  wire logic               scan_in,                // One-cycle pulse per scan call.
    input  wire logic               enable_in,              // Instruction enable input.
    input  wire logic signed [15:0] process_input_raw_in,   // Raw PV word.
    input  wire logic signed [15:0] cascade_setpoint_in,    // Cascade setpoint.
    input  wire logic signed [15:0] tracking_out_input_in,  // Tracking MV.
    input  wire logic        [2:0]  mode_sel_in,            // Mode bits 0..1, tracking bit 2.
    input  wire logic        [15:0] prop_gain_in,           // Gain 0..32767.
    input  wire logic        [15:0] integral_time_in,       // Integral time.
    input  wire logic        [15:0] derivative_time_in,     // Derivative time.
    input  wire logic        [15:0] deadband_width_in,      // Gap 0..1000.
    input  wire logic signed [15:0] initial_auto_setpoint_in, // Initial setpoint.
    input  wire logic        [15:0] pv_filter_coef_in,      // Filter coefficient 0..999.
    input  wire logic        [15:0] setpoint_rate_limit_in, // Setpoint step limit.
    input  wire logic        [15:0] manual_rate_limit_in,   // Manual step limit.
    input  wire logic        [2:0]  initial_status_word_in, // Init mode and direction.
    input  wire logic signed [15:0] output_upper_clamp_in,  // MV upper clamp.
    input  wire logic signed [15:0] output_lower_clamp_in,  // MV lower clamp.
    input  wire logic        [15:0] output_rate_limit_in,   // MV step limit.
    input  wire logic signed [15:0] interval_count_in,      // Scans per calculation.
    input  wire logic signed [15:0] manual_out_input_in,    // Manual MV from engine.
    input  wire logic               manual_out_wr_in,       // Engine writes manual MV.
    input  wire logic signed [15:0] auto_setpoint_in,       // Auto setpoint from engine.
    input  wire logic               auto_setpoint_wr_in,    // Engine writes auto setpoint.
    output logic                    done_out,               // Flag, one pulse per calculation.
    output logic signed      [15:0] manipulated_output_out, // MV word.
    output logic signed      [15:0] manual_out_input_out,   // Manual MV as held.
    output logic signed      [15:0] auto_setpoint_out,      // Auto setpoint as held.
    output logic             [1:0]  mode_out,               // Active mode bits.
    output logic signed      [15:0] last_error_out,         // Last error.
    output logic signed      [15:0] last_deriv_out,         // Last derivative.
    output logic signed      [15:0] last_pv_out,            // Last filtered PV.
    output logic signed      [15:0] last_sv_out,            // Last setpoint.
    output logic signed      [15:0] integral_remainder_out, // Integral remainder.
    output logic signed      [15:0] derivative_remainder_out, // Derivative remainder.
    output logic             [15:0] scan_count_out,         // Internal scan counter.
    output logic             [31:0] interval_ms_out         // Control interval in ms.
);
    // Elaboration check on the scan period.
    if (SCAN_MS < PPID_SCAN_MIN_MS || SCAN_MS > PPID_SCAN_MAX_MS || (SCAN_MS % PPID_SCAN_STEP_MS) != 0)
        $error("ppid_core: scan period out of range");

    typedef struct packed {
        ppid_state_t        st;
        logic               done;
        logic signed [15:0] mv;
        logic signed [15:0] manual_out_input;
        logic signed [15:0] auto_setpoint;
        logic        [1:0]  mode;
        logic signed [15:0] e_last;
        logic signed [15:0] d_last;
        logic signed [15:0] pv_last;
        logic signed [15:0] sv_last;
        logic signed [15:0] ir;
        logic signed [15:0] dr;
        logic        [15:0] cnt;
    } ppid_regs_t;

    ppid_regs_t s_r;
    ppid_regs_t s_nxt;

    logic signed [15:0] pv_w;
    ppid_div_if         div_i ();
    ppid_div_if         div_d ();

    ppid_pv_filter u_filt (
        .raw_in  (process_input_raw_in),
        .last_in (s_r.pv_last),
        .coef_in (pv_filter_coef_in),
        .pv_out  (pv_w)
    );
    ppid_div u_div_i (.d(div_i.rsp));
    ppid_div u_div_d (.d(div_d.rsp));

    logic        [15:0] n_w;
    logic signed [31:0] dt_w;
    logic signed [15:0] sv_w;
    logic signed [15:0] err_w;
    logic signed [15:0] gap_w;
    logic signed [15:0] mv_cand;
    logic signed [15:0] mv_lim;
    logic signed [15:0] step_w;
    logic signed [15:0] dd_w;
    logic signed [47:0] inc_w;
    logic signed [47:0] inc_noi;
    logic signed [15:0] dmv_w;
    logic signed [15:0] dmv_noi;
    logic               reverse_w;
    logic               track_w;

    // Rate limit a move from a base value to a target value.
    function automatic logic signed [15:0] ppid_rate(input logic signed [15:0] base,
                                                     input logic signed [15:0] tgt,
                                                     input logic        [15:0] lim);
        logic signed [17:0] diff;
        diff = 18'(tgt) - 18'(base);
        if (diff > 18'(signed'({1'b0, lim})))
            return ppid_sat16(48'(base) + 48'(signed'({1'b0, lim})));
        else if (diff < -18'(signed'({1'b0, lim})))
            return ppid_sat16(48'(base) - 48'(signed'({1'b0, lim})));
        else
            return tgt;
    endfunction

    // Datapath: setpoint, error, PID terms and output shaping.
    always_comb begin
        n_w       = (interval_count_in < 16'sh1) ? 16'h0001 : interval_count_in;
        dt_w      = 32'(n_w) * 32'(SCAN_MS);
        reverse_w = initial_status_word_in[PPID_DIR_BIT];
        track_w   = mode_sel_in[PPID_TRACK_BIT];
        if (s_r.mode == PPID_MODE_CAS)
            sv_w = cascade_setpoint_in;
        else
            sv_w = ppid_rate(s_r.sv_last, s_r.auto_setpoint, setpoint_rate_limit_in);
        err_w = ppid_sat16(48'(sv_w) - 48'(pv_w));
        gap_w = (deadband_width_in > PPID_GAP_MAX) ? PPID_GAP_MAX : deadband_width_in;
        if (gap_w != 16'sh0 && err_w <= gap_w && err_w >= -gap_w)
            err_w = 16'sh0;
        div_i.num = (integral_time_in == PPID_ZERO) ? 48'sh0 : 48'(err_w) * 48'(dt_w) + 48'(s_r.ir);
        div_i.den = 32'(integral_time_in);
        div_d.num = 48'(signed'({1'b0, derivative_time_in})) * 48'(s_r.pv_last - pv_w)
                  - 48'(dt_w) * 48'(s_r.d_last) + 48'(s_r.dr);
        div_d.den = dt_w + 32'(derivative_time_in / PPID_ETA_DIV);
        dd_w      = 16'(div_d.quo);
        inc_noi   = 48'(err_w - s_r.e_last) + 48'(dd_w);
        inc_w     = inc_noi + 48'(div_i.quo);
        dmv_w     = ppid_sat16((48'(signed'({1'b0, prop_gain_in})) * inc_w) / 48'sd100);
        dmv_noi   = ppid_sat16((48'(signed'({1'b0, prop_gain_in})) * inc_noi) / 48'sd100);
        mv_cand = reverse_w ? ppid_sat16(48'(s_r.mv) + 48'(dmv_w)) : ppid_sat16(48'(s_r.mv) - 48'(dmv_w));
        step_w  = ppid_rate(s_r.mv, mv_cand, output_rate_limit_in);
        mv_lim  = ppid_clamp(step_w, output_lower_clamp_in, output_upper_clamp_in);
    end

    // State update for initialization, scan counting and calculation.
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (manual_out_wr_in)
            s_nxt.manual_out_input = manual_out_input_in;
        if (auto_setpoint_wr_in)
            s_nxt.auto_setpoint = auto_setpoint_in;
        case (s_r.st)
            PPID_ST_IDLE: begin
                if (enable_in)
                    s_nxt.st = PPID_ST_WAIT;
            end
            PPID_ST_WAIT: begin
                if (scan_in) begin
                    s_nxt.cnt = s_r.cnt + 16'h0001;
                    if (s_r.cnt + 16'h0001 >= n_w)
                        s_nxt.st = PPID_ST_CALC;
                end
            end
            PPID_ST_CALC: begin
                s_nxt.cnt  = PPID_CNT_RST;
                s_nxt.st   = PPID_ST_WAIT;
                s_nxt.done = 1'b1;
                s_nxt.mode = mode_sel_in[PPID_MODE_HI:PPID_MODE_LO];
                if (s_r.mode == PPID_MODE_MAN) begin
                    s_nxt.mv = ppid_rate(s_r.mv, s_r.manual_out_input, manual_rate_limit_in);
                end else if (track_w) begin
                    s_nxt.mv  = ppid_clamp(tracking_out_input_in, output_lower_clamp_in, output_upper_clamp_in);
                    s_nxt.manual_out_input = s_nxt.mv;
                end else begin
                    s_nxt.mv      = mv_lim;
                    s_nxt.e_last  = err_w;
                    s_nxt.d_last  = ppid_sat16(48'(s_r.d_last) + 48'(dd_w));
                    s_nxt.pv_last = pv_w;
                    s_nxt.sv_last = sv_w;
                    s_nxt.dr      = 16'(div_d.rem);
                    s_nxt.ir      = 16'(div_i.rem);
                    if (mv_lim != mv_cand && ((mv_cand > mv_lim) == ((div_i.quo > 0) == reverse_w))
                        && div_i.quo != 16'sh0) begin
                        s_nxt.mv = ppid_clamp(ppid_rate(s_r.mv, reverse_w
                                   ? ppid_sat16(48'(s_r.mv) + 48'(dmv_noi))
                                   : ppid_sat16(48'(s_r.mv) - 48'(dmv_noi)), output_rate_limit_in),
                                   output_lower_clamp_in, output_upper_clamp_in);
                        s_nxt.ir = PPID_ZERO;
                    end
                    s_nxt.manual_out_input = s_nxt.mv;
                    if (s_r.mode == PPID_MODE_CAS)
                        s_nxt.auto_setpoint = cascade_setpoint_in;
                end
            end
            default: s_nxt.st = PPID_ST_IDLE;
        endcase
        if (!enable_in) begin
            s_nxt.st      = PPID_ST_IDLE;
            s_nxt.mode    = initial_status_word_in[PPID_MODE_HI:PPID_MODE_LO];
            s_nxt.auto_setpoint     = initial_auto_setpoint_in;
            s_nxt.manual_out_input     = s_r.mv;
            s_nxt.mv      = s_r.mv;
            s_nxt.e_last  = PPID_ZERO;
            s_nxt.d_last  = PPID_ZERO;
            s_nxt.pv_last = PPID_ZERO;
            s_nxt.sv_last = PPID_ZERO;
            s_nxt.ir      = PPID_ZERO;
            s_nxt.dr      = PPID_ZERO;
            s_nxt.cnt     = PPID_CNT_RST;
            s_nxt.done    = 1'b0;
        end
    end

    // Of reset and disable, only the system reset clears MV; disabling the block leaves it alone.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            s_r <= '{st: PPID_ST_IDLE, mode: PPID_MODE_MAN, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done_out                 = s_r.done;
    assign manipulated_output_out   = s_r.mv;
    assign manual_out_input_out     = s_r.manual_out_input;
    assign auto_setpoint_out        = s_r.auto_setpoint;
    assign mode_out                 = s_r.mode;
    assign last_error_out           = s_r.e_last;
    assign last_deriv_out           = s_r.d_last;
    assign last_pv_out              = s_r.pv_last;
    assign last_sv_out              = s_r.sv_last;
    assign integral_remainder_out   = s_r.ir;
    assign derivative_remainder_out = s_r.dr;
    assign scan_count_out           = s_r.cnt;
    assign interval_ms_out          = 32'(dt_w);
endmodule

/* ppid_core_chk.sv */
// Concurrent checks on the ports of the PID core.
`timescale 1ns/1ps
module ppid_core_chk
    import ppid_pkg::*;
#(
    parameter int SCAN_MS = 10                                 // Scan period in ms.
)
(
    input wire logic               clk_sys_in,                 // Clock.
    input wire logic               sys_rst_in,                 // Reset.
    input wire logic               scan_in,                    // Scan call.
    input wire logic               enable_in,                  // Enable.
    input wire logic signed [15:0] initial_auto_setpoint_in,   // Initial setpoint.
    input wire logic        [2:0]  initial_status_word_in,     // Initial status.
    input wire logic signed [15:0] interval_count_in,          // Scans per calculation.
    input wire logic               done_out,                   // Calculation flag.
    input wire logic signed [15:0] manipulated_output_out,     // MV.
    input wire logic signed [15:0] manual_out_input_out,       // Manual MV.
    input wire logic signed [15:0] auto_setpoint_out,          // Auto setpoint.
    input wire logic        [1:0]  mode_out,                   // Mode.
    input wire logic signed [15:0] last_error_out,             // Last error.
    input wire logic signed [15:0] last_pv_out,                // Last PV.
    input wire logic signed [15:0] last_sv_out,                // Last setpoint.
    input wire logic        [15:0] scan_count_out,             // Scan counter.
    input wire logic        [31:0] interval_ms_out             // Interval in ms.
);
    logic [1:0] init_mode;

    // Status mode field as a signal, so its past can be taken.
    assign init_mode = initial_status_word_in[1:0];

    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    a_done_after_scan: assert property (done_out |-> $past(scan_in, 2) || $past(scan_in, 3))
        else $error("Calculation flag without a scan call before it.");
    a_done_one_cycle: assert property (done_out |=> !done_out)
        else $error("Calculation flag stood longer than one cycle.");
    a_idle_no_flag: assert property (!enable_in [*3] |-> !done_out)
        else $error("Calculation flag raised while disabled.");
    a_init_copies: assert property (!enable_in [*2] |-> mode_out == $past(init_mode)
        && auto_setpoint_out == $past(initial_auto_setpoint_in))
        else $error("Initialization did not load mode and setpoint.");
    a_init_clears: assert property (!enable_in [*2] |-> last_error_out == 16'sh0000
        && last_pv_out == 16'sh0000 && last_sv_out == 16'sh0000 && scan_count_out == 16'h0000)
        else $error("Initialization left working state set.");
    a_init_keeps_mv: assert property (!enable_in [*3] |-> $stable(manipulated_output_out)
        && manual_out_input_out == manipulated_output_out)
        else $error("Initialization moved MV or missed the manual copy.");
    a_interval_value: assert property (interval_ms_out ==
        32'((interval_count_in < 16'sh0001) ? SCAN_MS : SCAN_MS * interval_count_in))
        else $error("Control interval word is wrong.");
    a_mv_on_calc: assert property (!$stable(manipulated_output_out) && !$past(sys_rst_in) |-> done_out)
        else $error("MV changed outside a calculation.");
endmodule

bind ppid_core ppid_core_chk #(.SCAN_MS(SCAN_MS)) u_chk (
    .clk_sys_in, .sys_rst_in, .scan_in, .enable_in, .initial_auto_setpoint_in, .initial_status_word_in,
    .interval_count_in, .done_out, .manipulated_output_out, .manual_out_input_out, .auto_setpoint_out,
    .mode_out, .last_error_out, .last_pv_out, .last_sv_out, .scan_count_out, .interval_ms_out
);

/* ppid_div.sv */
// Combinational signed divider that returns quotient and carried remainder.
`timescale 1ns/1ps
module ppid_div
    import ppid_pkg::*;
(
    ppid_div_if.rsp d    // Division request and answer.
);
    logic signed [47:0] q_w;
    logic signed [47:0] r_w;

    // A zero divisor yields zero, so callers need no guard of their own.
    always_comb begin
        q_w = 48'sh0;
        r_w = 48'sh0;
        if (d.den != 32'sh0) begin
            q_w = d.num / 48'(d.den);
            r_w = d.num % 48'(d.den);
        end
        d.quo = ppid_sat16(q_w);
        d.rem = r_w[31:0];
    end
endmodule

/* ppid_div_if.sv */
// Interface carrying one signed division request and its quotient and remainder.
`timescale 1ns/1ps
interface ppid_div_if;
    logic signed [47:0] num;
    logic signed [31:0] den;
    logic signed [31:0] quo;
    logic signed [31:0] rem;
    modport req (output num, output den, input quo, input rem);
    modport rsp (input num, input den, output quo, output rem);
endinterface

/* ppid_pkg.sv */
// Package with scaling limits, field positions and reset values of the PID block.
package ppid_pkg;
    localparam int          PPID_W          = 16;
    localparam logic [15:0] PPID_PV_MAX     = 16'h2710;
    localparam logic [15:0] PPID_GAIN_MAX   = 16'h7FFF;
    localparam logic [15:0] PPID_GAP_MAX    = 16'h03E8;
    localparam logic [15:0] PPID_FT_MAX     = 16'h03E7;
    localparam logic [15:0] PPID_FT_ONE     = 16'h03E8;
    localparam logic [15:0] PPID_RATE_MAX   = 16'h2710;
    localparam logic [15:0] PPID_MV_MIN     = 16'hF63C;
    localparam logic [15:0] PPID_MV_MAX     = 16'h30D4;
    localparam logic [15:0] PPID_CNT_MAX    = 16'h7FFF;
    localparam logic [15:0] PPID_ETA_DIV    = 16'h000A;
    localparam int          PPID_MODE_LO    = 0;
    localparam int          PPID_MODE_HI    = 1;
    localparam int          PPID_TRACK_BIT  = 2;
    localparam int          PPID_DIR_BIT    = 2;
    localparam logic [1:0]  PPID_MODE_MAN   = 2'h0;
    localparam logic [1:0]  PPID_MODE_AUTO  = 2'h1;
    localparam logic [1:0]  PPID_MODE_CAS   = 2'h2;
    localparam logic [15:0] PPID_ZERO       = 16'h0000;
    localparam logic [15:0] PPID_CNT_RST    = 16'h0000;
    localparam int          PPID_SCAN_MIN_MS = 10;
    localparam int          PPID_SCAN_MAX_MS = 200;
    localparam int          PPID_SCAN_STEP_MS = 10;

    typedef enum logic [2:0] {
        PPID_ST_IDLE = 3'h1,
        PPID_ST_WAIT = 3'h2,
        PPID_ST_CALC = 3'h4
    } ppid_state_t;

    // Saturate a wide signed value into a signed 16-bit word.
    function automatic logic signed [15:0] ppid_sat16(input logic signed [47:0] v);
        if (v > 48'sh7FFF)
            return 16'sh7FFF;
        else if (v < -48'sh8000)
            return 16'sh8000;
        else
            return v[15:0];
    endfunction

    // Clamp a signed word between a lower and an upper bound.
    function automatic logic signed [15:0] ppid_clamp(input logic signed [15:0] v,
                                                      input logic signed [15:0] lo,
                                                      input logic signed [15:0] hi);
        if (v > hi)
            return hi;
        else if (v < lo)
            return lo;
        else
            return v;
    endfunction
endpackage

/* ppid_pv_filter.sv */
// First-order filter applied to the raw process input.
`timescale 1ns/1ps
module ppid_pv_filter
    import ppid_pkg::*;
(
    input  wire logic signed [15:0] raw_in,     // Raw process input.
    input  wire logic signed [15:0] last_in,    // Previous filtered value.
    input  wire logic        [15:0] coef_in,    // Filter coefficient 0..999.
    output logic signed      [15:0] pv_out      // New filtered value.
);
    logic        [15:0] ft_w;
    logic signed [47:0] acc_w;

    // The coefficient is capped so an out-of-range word cannot freeze the input.
    always_comb begin
        ft_w  = (coef_in > PPID_FT_MAX) ? PPID_FT_MAX : coef_in;
        acc_w = 48'(raw_in) * 48'(signed'({1'b0, PPID_FT_ONE - ft_w}))
              + 48'(last_in) * 48'(signed'({1'b0, ft_w}));
        pv_out = ppid_sat16(acc_w / 48'(signed'({1'b0, PPID_FT_ONE})));
    end
endmodule

/* ppid_scan_eng.sv */
// Scan engine model that issues evenly spaced scan calls to the PID core.
`timescale 1ns/1ps
module ppid_scan_eng #(
    parameter int GAP = 4           // Cycles between scan calls, at least two.
)
(
    input  wire logic clk_sys_in,   // System clock.
    input  wire logic sys_rst_in,   // Synchronous reset, active high.
    input  wire logic run_in,       // Engine is running the program.
    output logic      scan_out      // One-cycle scan call.
);
    int cnt;

    // Low from time zero, so the core never sees an unknown call.
    initial scan_out = 1'b0;

    always @(negedge clk_sys_in) begin
        if (sys_rst_in || !run_in) begin
            cnt <= 0;
            scan_out <= 1'b0;
        end else begin
            cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
            scan_out <= (cnt == 0);
        end
    end
endmodule

/* tb_top.sv */
// Self-checking bench for the PID core with an integer reference model.
`timescale 1ns/1ps
module tb_top;
    import ppid_pkg::*;
    localparam int SCAN_MS = 20;
    logic               clk = 1'b0, rst = 1'b1, en = 1'b0, run = 1'b0, mwr = 1'b0, awr = 1'b0;
    logic               scan, done;
    logic signed [15:0] process_input_raw = '0, cascade_setpoint = '0, tracking_out_input = '0, initial_auto_setpoint = '0, lo = '0, hi = '0, ncnt = '0, mval = '0, aval = '0;
    logic        [15:0] kp = '0, ti = '0, td = '0, gap = '0, ft = '0, sprl = '0, mrl = '0, orl = '0;
    logic        [2:0]  msel = '0, sts = '0;
    logic signed [15:0] mv, mo, ao, le, lpv, lsv, ld, ir, dr;
    logic        [15:0] cnt, seed = 16'hE23E;
    logic        [1:0]  mode;
    logic        [31:0] ims;
    int                 err_total = 0, checks_done = 0, scans = 0, m_mv = 0, tgt, rate, k, j;
    int                 ntab[4] = '{0, -5, 1, 3};
    int                 ttab[3] = '{12500, -2500, 3000};

    ppid_scan_eng #(.GAP(4)) eng (.clk_sys_in(clk), .sys_rst_in(rst), .run_in(run), .scan_out(scan));
    ppid_core #(.SCAN_MS(SCAN_MS)) dut (
        .clk_sys_in(clk), .sys_rst_in(rst), .scan_in(scan), .enable_in(en), .process_input_raw_in(process_input_raw),
        .cascade_setpoint_in(cascade_setpoint), .tracking_out_input_in(tracking_out_input), .mode_sel_in(msel), .prop_gain_in(kp),
        .integral_time_in(ti), .derivative_time_in(td), .deadband_width_in(gap), .initial_auto_setpoint_in(initial_auto_setpoint),
        .pv_filter_coef_in(ft), .setpoint_rate_limit_in(sprl), .manual_rate_limit_in(mrl),
        .initial_status_word_in(sts), .output_upper_clamp_in(hi), .output_lower_clamp_in(lo),
        .output_rate_limit_in(orl), .interval_count_in(ncnt), .manual_out_input_in(mval),
        .manual_out_wr_in(mwr), .auto_setpoint_in(aval), .auto_setpoint_wr_in(awr), .done_out(done),
        .manipulated_output_out(mv), .manual_out_input_out(mo), .auto_setpoint_out(ao), .mode_out(mode),
        .last_error_out(le), .last_deriv_out(ld), .last_pv_out(lpv), .last_sv_out(lsv),
        .integral_remainder_out(ir), .derivative_remainder_out(dr), .scan_count_out(cnt), .interval_ms_out(ims)
    );

    // A 100 ns clock period.
    always #50 clk = ~clk;

    // Count scan calls to judge calculation spacing.
    always @(posedge clk)
        if (scan === 1'b1)
            scans <= scans + 1;

    // Shift-register values, the same on every run.
    function automatic int rnd(input int m);
        seed = {1'b0, seed[15:1]} ^ (seed[0] ? 16'hB400 : 16'h0000);
        return int'(seed) % m;
    endfunction

    task automatic chk(input logic [31:0] got, input int exp, input string what);
        checks_done++;
        if (got !== 32'(exp)) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %0d expected %0d", $time, what, $signed(got), exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // A hung core would otherwise stall the run, so every wait has a bound.
    task automatic wait_done();
        for (int i = 0; i < 400; i++) begin
            @(negedge clk);
            if (done === 1'b1)
                return;
        end
        err_total++;
        $display("MISMATCH t=%0t no calculation finished", $time);
        give_verdict();
    endtask

    task automatic calcs(input int c);
        for (int i = 0; i < c; i++)
            wait_done();
    endtask

    // Writes land while the core waits, never in a calculation cycle.
    task automatic wr(input bit to_auto, input int v);
        mval = 16'(v);
        aval = 16'(v);
        mwr = !to_auto;
        awr = to_auto;
        @(negedge clk);
        mwr = 1'b0;
        awr = 1'b0;
    endtask

    task automatic init(input logic [2:0] s, input logic [2:0] m);
        run = 1'b0;
        en = 1'b0;
        sts = s;
        msel = m;
        repeat (4) @(negedge clk);
        chk(mode, s[1:0], "init mode");
        chk(ao, initial_auto_setpoint, "init auto setpoint");
        chk(mo, m_mv, "init manual copy");
        chk(mv, m_mv, "mv kept");
        chk(lpv, 0, "pv cleared");
        chk({ld, ir | dr}, 0, "state clear");
        chk(done, 0, "flag low");
        en = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        // Interval counts of zero and below act as one.
        foreach (ntab[i]) begin
            ncnt = 16'(ntab[i]);
            init(3'h0, 3'h0);
            j = (ntab[i] < 1) ? 1 : ntab[i];
            chk(ims, j * SCAN_MS, "interval ms");
            run = 1'b1;
            wait_done();
            scans = 0;
            wait_done();
            chk(scans, j, "scans per calc");
        end
        // Manual mode: narrow clamps and a tiny MV step limit must not bite.
        tgt = rnd(15001) - 2500;
        rate = rnd(3000) + 2000;
        mrl = 16'(rate);
        hi = 16'sd100;
        orl = 16'h0001;
        init(3'h0, 3'h0);
        wr(1'b0, tgt);
        run = 1'b1;
        for (k = 0; k < 8; k++) begin
            wait_done();
            m_mv = (tgt > m_mv + rate) ? m_mv + rate : (tgt < m_mv - rate) ? m_mv - rate : tgt;
            chk(mv, m_mv, "manual ramp");
        end
        // Tracking in auto: clamps apply, the step limit does not.
        lo = -16'sd500;
        hi = 16'sd8000;
        init(3'h1, 3'h5);
        run = 1'b1;
        foreach (ttab[i]) begin
            tracking_out_input = 16'(ttab[i]);
            calcs(3);
            m_mv = (ttab[i] > 8000) ? 8000 : (ttab[i] < -500) ? -500 : ttab[i];
            chk(mv, m_mv, "tracked mv");
            chk(mo, m_mv, "manual follows mv");
        end
        // Direct and reverse action on a steady error of -1000 at unit gain.
        process_input_raw = 16'sd6000;
        initial_auto_setpoint = 16'sd5000;
        kp = 16'd100;
        sprl = 16'd10000;
        orl = 16'd10000;
        lo = -16'sd2500;
        hi = 16'sd12500;
        for (k = 0; k < 2; k++) begin
            init({k[0], 2'h1}, 3'h1);
            run = 1'b1;
            calcs(3);
            m_mv += k ? -1000 : 1000;
            chk(mv, m_mv, "action direction");
            chk(le, -1000, "error word");
            chk(lpv, 6000, "unfiltered pv");
            chk(lsv, 5000, "auto setpoint used");
        end
        // Auto setpoint written by the engine is approached by the step limit.
        kp = 16'd0;
        initial_auto_setpoint = 16'sd2000;
        sprl = 16'd1500;
        init(3'h1, 3'h1);
        wr(1'b1, 5000);
        run = 1'b1;
        for (k = 1; k < 5; k++) begin
            wait_done();
            chk(lsv, (1500 * k > 5000) ? 5000 : 1500 * k, "setpoint ramp");
        end
        // Cascade with a half filter; zero gain must hold MV whatever the other terms are.
        tgt = rnd(10001);
        cascade_setpoint = 16'(tgt);
        rate = rnd(2500);
        process_input_raw = 16'(4 * rate);
        ft = 16'd500;
        sprl = 16'd1;
        ti = 16'(rnd(32768));
        td = 16'(rnd(32768));
        gap = 16'(rnd(1001));
        init(3'h2, 3'h2);
        run = 1'b1;
        wait_done();
        chk(lpv, 2 * rate, "filtered pv first");
        chk(lsv, tgt, "cascade setpoint");
        wait_done();
        chk(lpv, 3 * rate, "filtered pv second");
        chk(ao, tgt, "setpoint copied");
        chk(mv, m_mv, "zero gain holds mv");
        chk(mo, m_mv, "manual copy");
        give_verdict();
    end
endmodule
